// >>> inc/op_decoder_defs.svh
// offsets, opcode patterns, field positions and reset values of the op decoder
`ifndef OP_DECODER_DEFS_SVH
`define OP_DECODER_DEFS_SVH
// ==========================================================
// register byte addresses
`define REG_INSTR 8'h00
`define REG_WORK 8'h04
`define REG_STATUS 8'h08
`define REG_PTR0 8'h0c
`define REG_PTR1 8'h10
`define REG_CYCLES 8'h14
`define REG_DIR_BASE 8'h20
`define REG_DIR_LAST 8'h3c
// ==========================================================
// status bit positions
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_ILLEGAL 5
`define ST_BUSY 8
// ==========================================================
// reset values
`define WORK_RST 8'h00
`define PTR_RST 16'h0000
`define TO_RST 1'b1
`define PD_RST 1'b1
// ==========================================================
// opcode patterns
`define OP_NOP 14'h0000
`define OP_SWRESET 14'h0001
`define OP_SLEEP 14'h0063
`define OP_WDCLR 14'h0064
`define PAT_DIR 11'h00c
`define PAT_LD_MM 11'h002
`define PAT_ST_MM 11'h003
`define PAT_PADD 7'h62
`define PAT_LD_IDX 7'h7e
`define PAT_ST_IDX 7'h7f
`define PAT_ANDL 6'h39
`define PAT_ADDL 6'h3e
`define PAT_ANDF 6'h05
`define PAT_ADDF 6'h07
// ==========================================================
// misc
`define PCL_ADDR 7'h02
`define DIR_COUNT 8
`endif

// >>> inc/op_decoder_pkg.sv
// types shared by the op decoder
package op_decoder_pkg;
	// ==========================================================
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_STALL = 4'b1000
	} seq_state_t;
	// ==========================================================
	// data memory request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} dmem_req_t;
endpackage

// >>> src/op_decoder.sv
// inherent, indirect and and/add instruction decoder with apb access
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_defs.svh"

module op_decoder
	import op_decoder_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output dmem_req_t DMEM_REQ,
	input wire logic [7:0] DMEM_RDATA,
	output logic SLEEP_REQ,
	output logic WDT_CLEAR,
	output logic SOFT_RESET
);
	// ==========================================================
	// state
	seq_state_t state_reg, state_next;
	logic [13:0] instr_reg;
	logic [7:0] work_reg, work_next;
	logic [15:0] ptr_reg [2];
	logic [15:0] ptr_next [2];
	logic [7:0] dir_reg [`DIR_COUNT];
	logic c_reg, dc_reg, z_reg, to_reg, pd_reg, illegal_reg;
	logic c_next, dc_next, z_next, to_next, pd_next;
	logic [15:0] ea_reg, upd_reg;
	logic [1:0] stall_reg;
	logic [1:0] cycles_reg;
	dmem_req_t dmem_reg, dmem_next;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic sleep_reg, wdclr_reg, swrst_reg;

	// ==========================================================
	// decode
	wire is_nop = instr_reg == `OP_NOP;
	wire is_swrst = instr_reg == `OP_SWRESET;
	wire is_sleep = instr_reg == `OP_SLEEP;
	wire is_wdclr = instr_reg == `OP_WDCLR;
	// standby and watchdog-clear words fall inside the direction range; they win
	wire is_dir = (instr_reg[13:3] == `PAT_DIR) & ~is_sleep & ~is_wdclr;
	wire is_ld_mm = instr_reg[13:3] == `PAT_LD_MM;
	wire is_st_mm = instr_reg[13:3] == `PAT_ST_MM;
	wire is_padd = instr_reg[13:7] == `PAT_PADD;
	wire is_ld_idx = instr_reg[13:7] == `PAT_LD_IDX;
	wire is_st_idx = instr_reg[13:7] == `PAT_ST_IDX;
	wire is_andl = instr_reg[13:8] == `PAT_ANDL;
	wire is_addl = instr_reg[13:8] == `PAT_ADDL;
	wire is_andf = instr_reg[13:8] == `PAT_ANDF;
	wire is_addf = instr_reg[13:8] == `PAT_ADDF;
	wire is_mm = is_ld_mm | is_st_mm;
	wire is_idx = is_ld_idx | is_st_idx;
	wire is_file = is_andf | is_addf;
	wire is_ind = is_mm | is_idx;
	// anything else runs as a nop but is flagged illegal
	wire known = is_nop | is_swrst | is_sleep | is_wdclr | is_dir | is_ind | is_padd |
		is_andl | is_addl | is_file;
	// pointer select sits at bit 2 for mm forms, bit 6 for literal forms
	wire psel_n = is_mm ? instr_reg[2] : instr_reg[6];
	wire [1:0] mm = instr_reg[1:0];
	wire [15:0] ptr_cur = ptr_reg[psel_n];
	wire [15:0] sext_k = {{10{instr_reg[5]}}, instr_reg[5:0]};
	wire [15:0] ptr_inc = ptr_cur + 16'h0001;
	wire [15:0] ptr_dec = ptr_cur - 16'h0001;
	wire [15:0] ptr_upd = mm[0] ? ptr_dec : ptr_inc;
	// mm: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
	wire [15:0] ea_mm = mm[1] ? ptr_cur : ptr_upd;
	wire [15:0] ea_idx = ptr_cur + sext_k;
	wire [15:0] ea_file = {9'h000, instr_reg[6:0]};
	// address latched in the read slot so a store reuses it unchanged
	wire [15:0] ea = is_mm ? ea_mm : (is_idx ? ea_idx : ea_file);
	wire needs_read = is_ld_mm | is_ld_idx | is_file;
	wire file_to_f = is_file & instr_reg[7];
	// writing the low program counter byte redirects fetch, costing a flush cycle
	wire pc_hit = file_to_f & (instr_reg[6:0] == `PCL_ADDR);
	wire ind_slow = is_ind & ea[15];
	wire [1:0] extra = {1'b0, pc_hit} + {1'b0, ind_slow};

	// ==========================================================
	// alu
	// literal and file forms share one adder and one and gate
	wire [7:0] operand = (is_andl | is_addl) ? instr_reg[7:0] : DMEM_RDATA;
	wire [8:0] sum9 = {1'b0, work_reg} + {1'b0, operand};
	// digit carry is the carry out of the low nibble
	wire [4:0] sum4 = {1'b0, work_reg[3:0]} + {1'b0, operand[3:0]};
	wire [7:0] and8 = work_reg & operand;
	wire [7:0] alu = (is_andl | is_andf) ? and8 : sum9[7:0];

	always_comb begin
		work_next = work_reg;
		ptr_next[0] = ptr_reg[0];
		ptr_next[1] = ptr_reg[1];
		c_next = c_reg;
		dc_next = dc_reg;
		z_next = z_reg;
		to_next = to_reg;
		pd_next = pd_reg;
		dmem_next = '0;
		if (state_reg == ST_READ) begin
			dmem_next.addr = ea;
			dmem_next.re = needs_read;
		end else if (state_reg == ST_EXEC) begin
			if (is_sleep) begin
				to_next = 1'b1;
				pd_next = 1'b0;
			end
			if (is_wdclr) begin
				to_next = 1'b1;
				pd_next = 1'b1;
			end
			if (is_padd) begin
				ptr_next[psel_n] = ptr_cur + sext_k;
			end
			if (is_mm) begin
				ptr_next[psel_n] = upd_reg;
			end
			if (is_ld_mm | is_ld_idx) begin
				work_next = DMEM_RDATA;
				z_next = DMEM_RDATA == 8'h00;
			end
			if (is_st_mm | is_st_idx) begin
				dmem_next.addr = ea_reg;
				dmem_next.wdata = work_reg;
				dmem_next.we = 1'b1;
			end
			if (is_andl | is_addl | is_file) begin
				z_next = alu == 8'h00;
				if (is_addl | is_addf) begin
					c_next = sum9[8];
					dc_next = sum4[4];
				end
				if (file_to_f) begin
					dmem_next.addr = ea_reg;
					dmem_next.wdata = alu;
					dmem_next.we = 1'b1;
				end else begin
					work_next = alu;
				end
			end
		end
	end

	// ==========================================================
	// apb decode
	wire setup = PSEL & ~PENABLE;
	wire is_dir_addr = (PADDR >= `REG_DIR_BASE) & (PADDR <= `REG_DIR_LAST);
	wire [2:0] dir_idx = PADDR[4:2];
	wire idle = state_reg == ST_IDLE;
	wire addr_ok = (PADDR[1:0] == 2'b00) & (PADDR <= `REG_CYCLES | is_dir_addr);
	// register writes are refused while an instruction is in flight
	wire bus_err = ~addr_ok | (PWRITE & ~idle);
	wire wr_go = PSEL & PENABLE & PWRITE & ~pslverr_reg;
	wire [31:0] status_word = {23'h0, ~idle, 2'b00, illegal_reg, to_reg, pd_reg, z_reg, dc_reg, c_reg};
	// read data latched at setup, so it only stands in the access cycle
	wire [31:0] rd_data = (PADDR == `REG_INSTR) ? {18'h0, instr_reg} :
		(PADDR == `REG_WORK) ? {24'h0, work_reg} :
		(PADDR == `REG_STATUS) ? status_word :
		(PADDR == `REG_PTR0) ? {16'h0, ptr_reg[0]} :
		(PADDR == `REG_PTR1) ? {16'h0, ptr_reg[1]} :
		(PADDR == `REG_CYCLES) ? {30'h0, cycles_reg} :
		is_dir_addr ? {24'h0, dir_reg[dir_idx]} : 32'h0;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= (setup & ~PWRITE & addr_ok) ? rd_data : 32'h0;
			pready_reg <= setup;
			pslverr_reg <= setup & bus_err;
		end
	end

	// ==========================================================
	// sequencer
	// one read slot, one execute slot, then nop stall cycles
	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = (wr_go & (PADDR == `REG_INSTR)) ? ST_READ : ST_IDLE;
			ST_READ: state_next = ST_EXEC;
			ST_EXEC: state_next = (extra != 2'd0) ? ST_STALL : ST_IDLE;
			ST_STALL: state_next = (stall_reg == 2'd1) ? ST_IDLE : ST_STALL;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			instr_reg <= `OP_NOP;
			ea_reg <= 16'h0;
			upd_reg <= 16'h0;
			stall_reg <= 2'd0;
			cycles_reg <= 2'd0;
			illegal_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (idle & wr_go & (PADDR == `REG_INSTR)) begin
				instr_reg <= PWDATA[13:0];
			end
			if (state_reg == ST_READ) begin
				ea_reg <= ea;
				upd_reg <= ptr_upd;
			end
			if (state_reg == ST_EXEC) begin
				// second cycle of a redirect and the slow-pointer cycle are plain nops
				stall_reg <= extra;
				cycles_reg <= 2'd1 + extra;
				illegal_reg <= ~known;
			end else if (state_reg == ST_STALL) begin
				stall_reg <= stall_reg - 2'd1;
			end
		end
	end

	// ==========================================================
	// architectural registers
	// software writes land only while idle, so they never meet an execute
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			work_reg <= `WORK_RST;
			ptr_reg[0] <= `PTR_RST;
			ptr_reg[1] <= `PTR_RST;
			c_reg <= 1'b0;
			dc_reg <= 1'b0;
			z_reg <= 1'b0;
			to_reg <= `TO_RST;
			pd_reg <= `PD_RST;
		end else begin
			work_reg <= (wr_go & (PADDR == `REG_WORK)) ? PWDATA[7:0] : work_next;
			ptr_reg[0] <= (wr_go & (PADDR == `REG_PTR0)) ? PWDATA[15:0] : ptr_next[0];
			ptr_reg[1] <= (wr_go & (PADDR == `REG_PTR1)) ? PWDATA[15:0] : ptr_next[1];
			c_reg <= c_next;
			dc_reg <= dc_next;
			z_reg <= z_next;
			to_reg <= to_next;
			pd_reg <= pd_next;
		end
	end

	// direction registers take the working register; software may also preload them
	for (genvar i = 0; i < `DIR_COUNT; i++) begin : g_dir
		always_ff @(posedge CORE_CLK) begin
			if (RST) begin
				dir_reg[i] <= 8'hff;
			end else if ((state_reg == ST_EXEC) & is_dir & (instr_reg[2:0] == 3'(i))) begin
				dir_reg[i] <= work_reg;
			end else if (wr_go & is_dir_addr & (dir_idx == 3'(i))) begin
				dir_reg[i] <= PWDATA[7:0];
			end
		end
	end

	// ==========================================================
	// side-effect pulses and memory port
	// pulses leave one edge after execute, together with any store
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			dmem_reg <= '0;
			sleep_reg <= 1'b0;
			wdclr_reg <= 1'b0;
			swrst_reg <= 1'b0;
		end else begin
			dmem_reg <= dmem_next;
			sleep_reg <= (state_reg == ST_EXEC) & is_sleep;
			wdclr_reg <= (state_reg == ST_EXEC) & is_wdclr;
			swrst_reg <= (state_reg == ST_EXEC) & is_swrst;
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign DMEM_REQ = dmem_reg;
	assign SLEEP_REQ = sleep_reg;
	assign WDT_CLEAR = wdclr_reg;
	assign SOFT_RESET = swrst_reg;
endmodule
`default_nettype wire

// >>> bench/dmem_model.sv
// data memory partner model with combinational read
`timescale 1ns/10ps
`default_nettype none
module dmem_model
	import op_decoder_pkg::*;
(
	input wire logic clk,
	input wire dmem_req_t req,
	output logic [7:0] rdata
);
	logic [7:0] mem [65536];
	logic [7:0] held;
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ 8'ha5;
		held = 8'h00;
	end
	// ==========
	// the core registers the address, so data follows it in the same cycle
	// idle cycles show the previous cycle's data inverted, so a sample one cycle late never matches
	assign rdata = req.re ? mem[req.addr] : ~held;
	always @(posedge clk) begin
		if (req.we)
			mem[req.addr] <= req.wdata;
		held <= rdata;
	end
endmodule
`default_nettype wire

// >>> bench/op_decoder_checker.sv
// port assertions for the op decoder
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_defs.svh"
module op_decoder_checker
	import op_decoder_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire dmem_req_t DMEM_REQ,
	input wire logic SLEEP_REQ,
	input wire logic WDT_CLEAR,
	input wire logic SOFT_RESET
);
	// ==========
	// instruction write, taken at the access edge
	wire go = PSEL && PENABLE && PWRITE && PADDR == `REG_INSTR;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	AST_READY: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing");
	AST_ERR_READY: assert property (PSLVERR |-> PREADY)
		else $error("stray error");
	AST_RDATA_ZERO: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0)
		else $error("rdata not zero");
	// results land a fixed number of edges after the write, stalls come later
	AST_LOAD_AT: assert property (DMEM_REQ.re |-> $past(go, 2))
		else $error("read slot");
	AST_STORE_AT: assert property (DMEM_REQ.we |-> $past(go, 3) && !DMEM_REQ.re)
		else $error("store slot");
	AST_SLEEP: assert property (SLEEP_REQ |-> $past(go, 3) && $past(PWDATA[13:0], 3) == `OP_SLEEP)
		else $error("sleep slot");
	AST_WDT: assert property (WDT_CLEAR |-> $past(go, 3) && $past(PWDATA[13:0], 3) == `OP_WDCLR)
		else $error("wdt slot");
	AST_SWRST: assert property (SOFT_RESET |-> $past(go, 3) && $past(PWDATA[13:0], 3) == `OP_SWRESET)
		else $error("reset slot");
endmodule
bind op_decoder op_decoder_checker i_chk (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.DMEM_REQ(DMEM_REQ), .SLEEP_REQ(SLEEP_REQ), .WDT_CLEAR(WDT_CLEAR), .SOFT_RESET(SOFT_RESET));
`default_nettype wire

// >>> bench/tb_op_decoder.sv
// self-checking bench for the op decoder
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_defs.svh"
module tb_op_decoder
	import op_decoder_pkg::*;
;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, e;
	logic c = 1'h0, dc = 1'h0, z = 1'h0, to = 1'h1, pd = 1'h1, ill = 1'h0;
	logic [7:0] paddr = 8'h00, w = 8'h00, rd;
	logic [31:0] pwdata = 32'h0, prdata, r, x;
	logic pready, pslverr, slp, wdc, swr;
	dmem_req_t req;
	logic [15:0] ptr [2];
	logic [7:0] mw [logic [15:0]];
	logic [13:0] fixed [11];
	int num_errors = 0, checked = 0, seed = 32'h6136, cyc, n_slp = 0, n_wdc = 0, n_swr = 0;
	always #5 clk = ~clk;
	op_decoder i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DMEM_REQ(req),
		.DMEM_RDATA(rd), .SLEEP_REQ(slp), .WDT_CLEAR(wdc), .SOFT_RESET(swr));
	dmem_model i_mem (.clk(clk), .req(req), .rdata(rd));
	// pulse counters, compared per instruction
	always @(posedge clk) begin
		n_slp += slp === 1'h1;
		n_wdc += wdc === 1'h1;
		n_swr += swr === 1'h1;
	end
	// ==========
	// checks and bus cycles
	task final_report;
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	function logic [7:0] rdm(input logic [15:0] a);
		return mw.exists(a) ? mw[a] : a[7:0] ^ 8'ha5;
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		if (n >= 20) begin
			num_errors++;
			final_report;
		end
	endtask
	// ==========
	// reference model of one instruction, then compare
	task automatic run(input logic [13:0] op);
		logic n = op[6], ind = 0, st = 0, al = 0, ad = 0, dr = 0;
		logic [15:0] a = ptr[op[6]] + {{10{op[5]}}, op[5:0]};
		logic [15:0] d = op[0] ? 16'hffff : 16'h0001;
		logic [7:0] v = op[7:0];
		logic [8:0] s;
		int k = 0;
		int p0 = n_slp, p1 = n_wdc, p2 = n_swr;
		ill = 0;
		cyc = 1;
		apb(1'h1, `REG_INSTR, {18'h0, op});
		apb(1'h1, `REG_INSTR, 32'h0);
		chk("busy_write", 32'h1, {31'h0, e});
		if (op[13:7] == `PAT_PADD)
			ptr[n] = a;
		else if (op[13:7] == `PAT_LD_IDX || op[13:7] == `PAT_ST_IDX) begin
			ind = 1;
			st = op[7];
		end else if (op[13:3] == `PAT_LD_MM || op[13:3] == `PAT_ST_MM) begin
			n = op[2];
			ind = 1;
			st = op[3];
			a = op[1] ? ptr[n] : ptr[n] + d;
			ptr[n] = ptr[n] + d;
		end else if (op[13:8] == `PAT_ANDF || op[13:8] == `PAT_ADDF) begin
			al = 1;
			ad = op[9];
			a = {9'h0, op[6:0]};
			v = rdm(a);
			cyc += op[7] && a == `PCL_ADDR;
		end else if (op[13:8] == `PAT_ANDL || op[13:8] == `PAT_ADDL) begin
			al = 1;
			ad = op[13:8] == `PAT_ADDL;
		end else if (op == `OP_SLEEP || op == `OP_WDCLR) begin
			to = 1;
			pd = op == `OP_WDCLR;
		end else if (op[13:3] == `PAT_DIR)
			dr = 1;
		else if (op != `OP_NOP && op != `OP_SWRESET)
			ill = 1;
		if (ind) begin
			cyc += a[15];
			if (st)
				mw[a] = w;
			else begin
				w = rdm(a);
				z = w == 8'h00;
			end
		end
		if (al) begin
			s = ad ? w + v : {1'h0, w & v};
			c = ad ? s[8] : c;
			dc = ad ? w[3:0] + v[3:0] > 15 : dc;
			z = s[7:0] == 8'h00;
			st = op[13:12] == 2'h0 && op[7];
			if (st)
				mw[a] = s[7:0];
			else
				w = s[7:0];
		end
		do begin
			apb(1'h0, `REG_STATUS, 32'h0);
			k++;
		end while (r[`ST_BUSY] !== 1'h0 && k < 9);
		if (r[`ST_BUSY] !== 1'h0) begin
			num_errors++;
			final_report;
		end
		chk("status", {26'h0, ill, to, pd, z, dc, c}, r);
		apb(1'h0, `REG_WORK, 32'h0);
		chk("work", {24'h0, w}, r);
		apb(1'h0, `REG_PTR0, 32'h0);
		chk("ptr0", {16'h0, ptr[0]}, r);
		apb(1'h0, `REG_PTR1, 32'h0);
		chk("ptr1", {16'h0, ptr[1]}, r);
		apb(1'h0, `REG_CYCLES, 32'h0);
		chk("cycles", cyc, r);
		if (st)
			chk("mem", {24'h0, mw[a]}, {24'h0, i_mem.mem[a]});
		if (dr) begin
			apb(1'h0, `REG_DIR_BASE + {3'h0, op[2:0], 2'h0}, 32'h0);
			chk("dir", {24'h0, w}, r);
		end
		chk("sleep_req", op == `OP_SLEEP, n_slp - p0);
		chk("wdt_clear", op == `OP_WDCLR, n_wdc - p1);
		chk("soft_reset", op == `OP_SWRESET, n_swr - p2);
	endtask
	// ==========
	// main sequence
	initial begin
		ptr = '{16'h0000, 16'h0000};
		fixed = '{{`PAT_ADDL, 8'hff}, {`PAT_DIR, 3'h5}, `OP_SLEEP, `OP_WDCLR, `OP_NOP, 14'h1000,
			{`PAT_ADDL, 8'h01}, {`PAT_ANDL, 8'h00}, {`PAT_ADDF, 8'h82}, {`PAT_ANDF, 8'h7f}, {`PAT_LD_IDX, 7'h5f}};
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		apb(1'h0, `REG_STATUS, 32'h0);
		chk("status_rst", 32'h18, r);
		apb(1'h0, `REG_DIR_BASE, 32'h0);
		chk("dir_rst", 32'hff, r);
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		apb(1'h1, `REG_PTR0, 32'hffff);
		ptr[0] = 16'hffff;
		run({`PAT_PADD, 7'h01});
		run({`PAT_PADD, 7'h60});
		foreach (fixed[i])
			run(fixed[i]);
		repeat (80) begin
			x = $random(seed);
			case (x[19:16])
				0: run({`PAT_PADD, x[6:0]});
				1: run({`PAT_LD_MM, x[2:0]});
				2: run({`PAT_ST_MM, x[2:0]});
				3: run({`PAT_LD_IDX, x[6:0]});
				4: run({`PAT_ST_IDX, x[6:0]});
				5: run({`PAT_ANDL, x[7:0]});
				6: run({`PAT_ADDL, x[7:0]});
				7: run({`PAT_ANDF, x[7:0]});
				8: run({`PAT_ADDF, x[7:0]});
				default: begin
					apb(1'h1, `REG_PTR0 + {x[20], 2'h0}, {16'h0, x[15:0]});
					ptr[x[20]] = x[15:0];
				end
			endcase
		end
		run(`OP_SWRESET);
		repeat (8) @(posedge clk);
		final_report;
	end
endmodule
`default_nettype wire
